// ==== src/swp_regs.vh ====
/*
  Constants for the strap and wake-up pin block: register offsets, field
  positions, reset values and timing counts.
  Assumes a 25 MHz aclk; counts are derived from the times below.
*/
`ifndef SWP_REGS_VH
`define SWP_REGS_VH

// Register byte offsets on the AXI4-Lite slave.
`define SWP_CTRL_OFF       8'h00
`define SWP_STATUS_OFF     8'h04
`define SWP_EVENT_OFF      8'h08
`define SWP_CFGBASE_OFF    8'h0c

// Reset values.
`define SWP_CTRL_RST       32'h0000_0000
`define SWP_EVENT_RST      2'h0

// Control register fields.
`define SWP_CTRL_SUPPLY    0
`define SWP_CTRL_PRESS     1
`define SWP_CTRL_SBO0      2
`define SWP_CTRL_SBO1      3
`define SWP_CTRL_LED1_LSB  4
`define SWP_CTRL_LED2_LSB  8
`define SWP_CTRL_MASK      32'h0000_077f

// Event register fields.
`define SWP_EV_BUTTON      0
`define SWP_EV_RING        1

// Configuration index/data pair base addresses.
`define SWP_CFG_BASE_LO    16'h002e
`define SWP_CFG_BASE_HI    16'h004e

// LED modes.
`define SWP_LED_OFF        3'h0
`define SWP_LED_ON         3'h1
`define SWP_LED_Q25HZ      3'h2
`define SWP_LED_HALFHZ     3'h3
`define SWP_LED_1HZ        3'h4
`define SWP_LED_4HZ        3'h5

// AXI responses.
`define SWP_RESP_OKAY      2'h0
`define SWP_RESP_SLVERR    2'h2

// Timing: times in their own units, and each count sized to its 24-bit counter at 25 MHz.
`define SWP_CLK_KHZ        25000
`define SWP_DEBOUNCE_MS    16
`define SWP_DEBOUNCE_CYC   24'd400000
`define SWP_BLINK_TICK_MS  125
`define SWP_BLINK_TICK_CYC 24'd3125000
`define SWP_RING_GAP_MS    200
`define SWP_RING_GAP_CYC   24'd5000000
`define SWP_RING_PULSES    4'h3

`endif

// ==== src/swp_debounce.v ====
/*
  Level debouncer: a new input level is accepted only after it has stayed
  unchanged for CYCLES consecutive clocks.
  Assumes the input is already synchronous to aclk.
*/
`timescale 1ns/100ps
`default_nettype none

module swp_debounce #(
  parameter [23:0] CYCLES = 24'd400000
) (
  // Clock and reset.
  input  wire       aclk,
  input  wire       aresetn,
  // Level in and accepted level out.
  input  wire       level,
  output reg        stable_q
);

  reg [23:0] cnt_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q    <= 24'h000000;
      stable_q <= 1'b1;
    end else if (level == stable_q) begin
      cnt_q <= 24'h000000;
    end else if (cnt_q >= CYCLES - 24'd1) begin
      cnt_q    <= 24'h000000;
      stable_q <= level;
    end else begin
      cnt_q <= cnt_q + 24'h000001;
    end
  end

endmodule // swp_debounce

`default_nettype wire

// ==== src/swp_led_blink.v ====
/*
  Two LED waveform generators sharing one prescaler.
  Assumes TICK is the half period of the fastest (4 Hz) waveform.
*/
`timescale 1ns/100ps
`default_nettype none
`include "swp_regs.vh"

module swp_led_blink #(
  parameter [23:0] TICK = 24'd3125000
) (
  // Clock and reset.
  input  wire       aclk,
  input  wire       aresetn,
  // Mode selects.
  input  wire [2:0] led1_mode,
  input  wire [2:0] led2_mode,
  // LED drives.
  output reg        led1_out,
  output reg        led2_out
);

  reg [23:0] pre_q;
  reg [4:0]  phase_q;

  function led_level;
    input [2:0] mode;
    input [4:0] ph;
    begin
      case (mode)
        `SWP_LED_ON:     led_level = 1'b1;
        `SWP_LED_Q25HZ:  led_level = ph[4];
        `SWP_LED_HALFHZ: led_level = ph[3];
        `SWP_LED_1HZ:    led_level = ph[2];
        `SWP_LED_4HZ:    led_level = ph[0];
        default:         led_level = 1'b0;
      endcase
    end
  endfunction

  // Each phase bit toggles at half the rate of the bit below it.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_q    <= 24'h000000;
      phase_q  <= 5'h00;
      led1_out <= 1'b0;
      led2_out <= 1'b0;
    end else begin
      if (pre_q >= TICK - 24'd1) begin
        pre_q   <= 24'h000000;
        phase_q <= phase_q + 5'h01;
      end else begin
        pre_q <= pre_q + 24'h000001;
      end
      led1_out <= led_level(led1_mode, phase_q);
      led2_out <= led_level(led2_mode, phase_q);
    end
  end

endmodule // swp_led_blink

`default_nettype wire

// ==== src/swp_top.v ====
/*
  Strap capture and standby wake-up pin logic with an AXI4-Lite register
  slave. Straps are latched on the trailing edge of the system reset pin.
  Assumes all pin inputs are asynchronous to aclk and that open-drain pins
  have external pull-ups; the bench resolves pins from the enables.
*/
`timescale 1ns/100ps
`default_nettype none
`include "swp_regs.vh"

module swp_top #(
  parameter [23:0] DEBOUNCE_CYCLES = `SWP_DEBOUNCE_CYC,
  parameter [23:0] BLINK_TICK      = `SWP_BLINK_TICK_CYC,
  parameter [23:0] RING_GAP        = `SWP_RING_GAP_CYC
) (
  // Clock and reset.
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address and data.
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // AXI4-Lite write response.
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // AXI4-Lite read.
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [31:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // System reset pin and strap pins.
  input  wire        sys_reset_n,
  input  wire        config_base_select_strap,
  input  wire        power_led_cfg_strap0,
  input  wire        power_led_cfg_strap1,
  input  wire        supply_on_polarity_strap,
  input  wire        test_strap,
  // Configuration pair decode.
  input  wire [15:0] io_addr,
  output wire        cfg_index_hit,
  output wire        cfg_data_hit,
  output reg         test_mode,
  // Shared pin 33: power button out, or standby_out0.
  output reg         power_button_out_n,
  output reg         power_button_out_oe,
  // Shared pin 34: supply on, or standby_out1.
  output reg         supply_on_out,
  output reg         supply_on_out_oe,
  // Shared pin 35: power button in, or standby_in2.
  input  wire        power_button_in_n,
  // Sleep-state inputs and ring input.
  input  wire        sleep_state3_in,
  input  wire        sleep_state5_in,
  input  wire        ring_in_n,
  // Power-up request, open drain.
  output reg         power_up_request_n,
  output reg         power_up_request_oe,
  // LEDs.
  output wire        led1_out,
  output wire        led2_out
);

  // Pin synchronisers; stage one feeds only stage two. Ring and button reset high, their idle level.
  localparam SYNC_W = 10;
  reg  [SYNC_W-1:0] sync1_q;
  reg  [SYNC_W-1:0] sync2_q;
  wire [SYNC_W-1:0] pins_raw;

  assign pins_raw = {ring_in_n, sleep_state5_in, sleep_state3_in, power_button_in_n,
                     test_strap, supply_on_polarity_strap, power_led_cfg_strap1,
                     power_led_cfg_strap0, config_base_select_strap, sys_reset_n};

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 10'h240;
      sync2_q <= 10'h240;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  wire sys_rst_s = sync2_q[0];
  wire btn_s     = sync2_q[6];
  wire slp3_s    = sync2_q[7];
  wire slp5_s    = sync2_q[8];
  wire ring_s    = sync2_q[9];

  // Strap latches, loaded only at the release of system reset.
  reg  sys_rst_prev_q;
  reg  base_sel_q;
  reg  plc0_q;
  reg  plc1_q;
  reg  polarity_q;
  wire rst_release = sys_rst_s & ~sys_rst_prev_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      sys_rst_prev_q <= 1'b0;
      base_sel_q     <= 1'b0;
      plc0_q         <= 1'b0;
      plc1_q         <= 1'b0;
      polarity_q     <= 1'b0;
      test_mode      <= 1'b0;
    end else begin
      sys_rst_prev_q <= sys_rst_s;
      if (rst_release) begin
        base_sel_q <= sync2_q[1];
        plc0_q     <= sync2_q[2];
        plc1_q     <= sync2_q[3];
        polarity_q <= sync2_q[4];
        test_mode  <= sync2_q[5];
      end
    end
  end

  // Power functions only when both straps are low; either high selects GPIO.
  wire power_mode = ~plc0_q & ~plc1_q;

  // Configuration pair placement.
  function cfg_hit;
    input [15:0] addr;
    input [15:0] base;
    begin
      cfg_hit = (addr == base);
    end
  endfunction

  wire [15:0] cfg_base = base_sel_q ? `SWP_CFG_BASE_HI : `SWP_CFG_BASE_LO;
  assign cfg_index_hit = cfg_hit(io_addr, cfg_base);
  assign cfg_data_hit  = cfg_hit(io_addr, cfg_base + 16'h0001);

  // Power button debounce; pressed is low.
  wire btn_stable;

  swp_debounce #(
    .CYCLES (DEBOUNCE_CYCLES)
  ) u_debounce (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .level    (btn_s),
    .stable_q (btn_stable)
  );

  reg  btn_prev_q;
  wire btn_pressed = ~btn_stable;
  wire btn_event   = power_mode & btn_pressed & ~btn_prev_q;

  // Ring pulse-train detector: enough falling edges without a long gap.
  reg        ring_prev_q;
  reg [3:0]  ring_cnt_q;
  reg [23:0] ring_gap_q;
  reg        ring_event;
  wire       ring_fall = ring_prev_q & ~ring_s;

  always @(posedge aclk) begin
    if (!aresetn) begin
      btn_prev_q  <= 1'b0;
      ring_prev_q <= 1'b1;
      ring_cnt_q  <= 4'h0;
      ring_gap_q  <= 24'h000000;
      ring_event  <= 1'b0;
    end else begin
      btn_prev_q  <= btn_pressed;
      ring_prev_q <= ring_s;
      ring_event  <= 1'b0;
      if (ring_fall) begin
        ring_gap_q <= 24'h000000;
        if (ring_cnt_q + 4'h1 >= `SWP_RING_PULSES) begin
          ring_cnt_q <= 4'h0;
          ring_event <= 1'b1;
        end else begin
          ring_cnt_q <= ring_cnt_q + 4'h1;
        end
      end else if (ring_gap_q >= RING_GAP - 24'd1) begin
        ring_gap_q <= 24'h000000;
        ring_cnt_q <= 4'h0;
      end else if (ring_cnt_q != 4'h0) begin
        ring_gap_q <= ring_gap_q + 24'h000001;
      end
    end
  end

  // Register file.
  reg [31:0] ctrl_q;
  reg [1:0]  event_q;

  function [31:0] strb_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      strb_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strb_merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  function mapped;
    input [31:0] addr;
    begin
      mapped = (addr[31:4] == 28'h0000000) && (addr[1:0] == 2'h0);
    end
  endfunction

  // AXI write path: address and data are taken independently.
  reg        aw_got_q;
  reg        w_got_q;
  reg [31:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;

  assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_q & ~s_axi_bvalid;

  wire aw_hs  = s_axi_awvalid & s_axi_awready;
  wire w_hs   = s_axi_wvalid & s_axi_wready;
  wire wr_go  = aw_got_q & w_got_q;
  wire wr_ok  = mapped(awaddr_q);
  wire [7:0] wr_off = awaddr_q[7:0];
  wire ev_clr_wr = wr_go & wr_ok & (wr_off == `SWP_EVENT_OFF) & wstrb_q[0];
  wire [1:0] ev_clr = ev_clr_wr ? wdata_q[1:0] : 2'h0;
  wire [1:0] ev_set = {ring_event, btn_event};

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q     <= 1'b0;
      w_got_q      <= 1'b0;
      awaddr_q     <= 32'h00000000;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SWP_RESP_OKAY;
      ctrl_q       <= `SWP_CTRL_RST;
      event_q      <= `SWP_EVENT_RST;
    end else begin
      if (aw_hs) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `SWP_RESP_OKAY : `SWP_RESP_SLVERR;
        if (wr_ok && wr_off == `SWP_CTRL_OFF) begin
          ctrl_q <= strb_merge(ctrl_q, wdata_q, wstrb_q) & `SWP_CTRL_MASK;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // A new event in the clearing cycle survives the clear.
      event_q <= (event_q & ~ev_clr) | ev_set;
    end
  end

  // AXI read path: data one cycle after the address is taken.
  assign s_axi_arready = ~s_axi_rvalid;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  reg [31:0] rd_word;

  always @* begin
    rd_word = 32'h00000000;
    case (s_axi_araddr[7:0])
      `SWP_CTRL_OFF:    rd_word = ctrl_q;
      `SWP_STATUS_OFF:  rd_word = {22'h000000, power_mode, btn_s, slp5_s, slp3_s, btn_pressed,
                                   test_mode, polarity_q, plc1_q, plc0_q, base_sel_q};
      `SWP_EVENT_OFF:   rd_word = {30'h00000000, event_q};
      `SWP_CFGBASE_OFF: rd_word = {16'h0000, cfg_base};
      default:          rd_word = 32'h00000000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `SWP_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= mapped(s_axi_araddr) ? rd_word : 32'h00000000;
      s_axi_rresp  <= mapped(s_axi_araddr) ? `SWP_RESP_OKAY : `SWP_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // LEDs.
  swp_led_blink #(
    .TICK (BLINK_TICK)
  ) u_led (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .led1_mode (ctrl_q[`SWP_CTRL_LED1_LSB +: 3]),
    .led2_mode (ctrl_q[`SWP_CTRL_LED2_LSB +: 3]),
    .led1_out  (led1_out),
    .led2_out  (led2_out)
  );

  // Pin drivers, registered so the pads never see decode glitches.
  wire supply_on = ctrl_q[`SWP_CTRL_SUPPLY];
  wire press_out = btn_pressed | ctrl_q[`SWP_CTRL_PRESS];

  always @(posedge aclk) begin
    if (!aresetn) begin
      power_button_out_n  <= 1'b0;
      power_button_out_oe <= 1'b0;
      supply_on_out       <= 1'b0;
      supply_on_out_oe    <= 1'b0;
      power_up_request_n  <= 1'b0;
      power_up_request_oe <= 1'b0;
    end else begin
      power_up_request_n  <= 1'b0;
      power_up_request_oe <= |event_q;
      if (power_mode) begin
        power_button_out_n  <= 1'b0;
        power_button_out_oe <= press_out;
        if (polarity_q) begin
          supply_on_out    <= supply_on;
          supply_on_out_oe <= 1'b1;
        end else begin
          supply_on_out    <= 1'b0;
          supply_on_out_oe <= supply_on;
        end
      end else begin
        power_button_out_n  <= ctrl_q[`SWP_CTRL_SBO0];
        power_button_out_oe <= 1'b1;
        supply_on_out       <= ctrl_q[`SWP_CTRL_SBO1];
        supply_on_out_oe    <= 1'b1;
      end
    end
  end

endmodule // swp_top

`default_nettype wire

// ==== dv/swp_top_props.sv ====
/*
  Protocol and pin checks for swp_top, bound to its ports.
  Assumes one clock domain, aclk, with aresetn as its synchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
`include "swp_regs.vh"

module swp_top_props (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pins.
  input wire logic        sys_reset_n,
  input wire logic [15:0] io_addr,
  input wire logic        cfg_index_hit,
  input wire logic        cfg_data_hit,
  input wire logic        test_mode,
  input wire logic        power_up_request_n,
  input wire logic        power_up_request_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // The capture lands a few cycles after the reset pin rises, so the hold check waits well past it.
  logic [3:0] quiet_q;
  always @(posedge aclk) begin
    if (!aresetn || !sys_reset_n) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end

  sequence wr_hs;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_hs;
    s_axi_arvalid && s_axi_arready;
  endsequence

  wr_resp_a: assert property (wr_hs |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  rd_resp_a: assert property (rd_hs |=> s_axi_rvalid) else $error("read data missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  r_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  b_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  wake_low_a: assert property (power_up_request_oe |-> !power_up_request_n) else $error("request not low");
  cfg_index_a: assert property (cfg_index_hit |-> !cfg_data_hit &&
    (io_addr == `SWP_CFG_BASE_LO || io_addr == `SWP_CFG_BASE_HI)) else $error("index decode wrong");
  cfg_data_a: assert property (cfg_data_hit |->
    (io_addr == `SWP_CFG_BASE_LO + 16'h1 || io_addr == `SWP_CFG_BASE_HI + 16'h1)) else $error("data decode wrong");
  strap_hold_a: assert property (quiet_q == 4'hf && $stable(io_addr) |->
    $stable(test_mode) && $stable(cfg_index_hit)) else $error("strap latch moved");
endmodule // swp_top_props

bind swp_top swp_top_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .sys_reset_n(sys_reset_n), .io_addr(io_addr),
  .cfg_index_hit(cfg_index_hit), .cfg_data_hit(cfg_data_hit), .test_mode(test_mode),
  .power_up_request_n(power_up_request_n), .power_up_request_oe(power_up_request_oe));
`default_nettype wire

// ==== dv/swp_chipset_model.sv ====
/*
  Chipset power logic model: reports the sleep state and wakes on a request.
  Assumes the request pin has a pull-up and the bench loads the sleep state.
*/
`timescale 1ns/100ps
`default_nettype none

module swp_chipset_model (
  // Clock.
  input wire logic       aclk,
  // Open-drain wake request from the block.
  input wire logic       power_up_request_n,
  input wire logic       power_up_request_oe,
  // Bench control of the sleep state.
  input wire logic       state_load,
  input wire logic [2:0] state_val,
  // Sleep-state pins to the block.
  output logic           sleep_state3_in,
  output logic           sleep_state5_in
);
  logic [2:0] state_q = 3'h0;
  wire        req_pin = power_up_request_oe ? power_up_request_n : 1'b1;

  always @(posedge aclk) begin
    if (state_load) state_q <= state_val;
    else if (!req_pin) state_q <= 3'h0;
  end
  assign sleep_state3_in = (state_q >= 3'h3);
  assign sleep_state5_in = (state_q >= 3'h4);
endmodule // swp_chipset_model
`default_nettype wire

// ==== dv/test_strap_and_wakeup_pins.sv ====
/*
  Self-checking bench for swp_top with a chipset model on the sleep pins.
  Assumes shortened debounce, blink and ring-gap parameters.
*/
`timescale 1ns/100ps
`default_nettype none
`include "swp_regs.vh"

module test_strap_and_wakeup_pins;
  localparam DEB = 8;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sys_reset_n, button_n, ring_n, st_load;
  logic        base_s, plc0_s, plc1_s, pol_s, test_s;
  logic [31:0] awaddr, wdata, araddr, rdv;
  logic [15:0] io_addr;
  logic [2:0]  st_val;
  logic [3:0]  wstrb;
  logic [1:0]  rs;
  wire         awready, wready, bvalid, arready, rvalid, ihit, dhit, tmode, pbo_n, pbo_oe, son, son_oe;
  wire         pur_n, pur_oe, led1, led2, slp3, slp5;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  integer      num_errors, total_checks, cyc;

  swp_top #(.DEBOUNCE_CYCLES(24'd8), .BLINK_TICK(24'd4), .RING_GAP(24'd50)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .sys_reset_n(sys_reset_n),
    .config_base_select_strap(base_s), .power_led_cfg_strap0(plc0_s), .power_led_cfg_strap1(plc1_s),
    .supply_on_polarity_strap(pol_s), .test_strap(test_s), .io_addr(io_addr), .cfg_index_hit(ihit),
    .cfg_data_hit(dhit), .test_mode(tmode), .power_button_out_n(pbo_n), .power_button_out_oe(pbo_oe),
    .supply_on_out(son), .supply_on_out_oe(son_oe), .power_button_in_n(button_n), .sleep_state3_in(slp3),
    .sleep_state5_in(slp5), .ring_in_n(ring_n), .power_up_request_n(pur_n), .power_up_request_oe(pur_oe),
    .led1_out(led1), .led2_out(led2));
  swp_chipset_model u_chipset (.aclk(aclk), .power_up_request_n(pur_n), .power_up_request_oe(pur_oe),
    .state_load(st_load), .state_val(st_val), .sleep_state3_in(slp3), .sleep_state5_in(slp5));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // The run needs under 10000 cycles; twice that means a hang.
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      test_done;
    end
  end

  task check(input [33:0] seen, input [33:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task settle;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask

  // Ready is looked at mid-cycle, where it is settled, and acted on at the following edge.
  task wr_reg(input [31:0] a, input [31:0] d);
    logic ah, wh, bh, bv;
    @(posedge aclk);
    {awvalid, wvalid, awaddr, wdata} <= {2'b11, a, d};
    bh = 1'b0;
    while (!bh) begin
      @(negedge aclk);
      {ah, wh, bv, bh, rs} = {awvalid && awready, wvalid && wready, bvalid, bvalid && bready, bresp};
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      bready <= bv && !bh;
    end
  endtask

  task rd_reg(input [31:0] a);
    logic ah, rh, rv;
    @(posedge aclk);
    {arvalid, araddr} <= {1'b1, a};
    rh = 1'b0;
    while (!rh) begin
      @(negedge aclk);
      {ah, rv, rh, rdv, rs} = {arvalid && arready, rvalid, rvalid && rready, rdata, rresp};
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      rready <= rv && !rh;
    end
  endtask

  task strap(input [4:0] s);
    @(posedge aclk);
    {test_s, pol_s, plc1_s, plc0_s, base_s} <= s;
    sys_reset_n <= 1'b0;
    repeat (3) @(posedge aclk);
    sys_reset_n <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask

  task io(input [15:0] a);
    @(posedge aclk);
    io_addr <= a;
    @(negedge aclk);
  endtask

  task pulse;
    @(posedge aclk);
    ring_n <= 1'b0;
    repeat (2) @(posedge aclk);
    ring_n <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask

  task t_reset;
    rd_reg(`SWP_CTRL_OFF);
    check(rdv, `SWP_CTRL_RST);
    rd_reg(`SWP_STATUS_OFF);
    check(rdv, 32'h0000_0300);
    rd_reg(`SWP_CFGBASE_OFF);
    check(rdv, 32'h0000_002e);
    io(16'h002f);
    check({ihit, dhit}, 2'b01);
    check(tmode, 1'b0);
    rd_reg(32'h0000_0010);
    check({rs, rdv}, {`SWP_RESP_SLVERR, 32'h0});
    wr_reg(32'h0000_0010, 32'hffff_ffff);
    check(rs, `SWP_RESP_SLVERR);
    wstrb <= 4'h1;
    wr_reg(`SWP_CTRL_OFF, 32'hffff_ffff);
    wstrb <= 4'hf;
    rd_reg(`SWP_CTRL_OFF);
    check(rdv, 32'h0000_007f);
    $display("reset test done");
  endtask

  task t_supply;
    wr_reg(`SWP_CTRL_OFF, 32'h1);
    settle;
    check({son, son_oe}, 2'b01);
    wr_reg(`SWP_CTRL_OFF, 32'h0);
    settle;
    check({son, son_oe}, 2'b00);
    strap(5'b01000);
    wr_reg(`SWP_CTRL_OFF, 32'h1);
    settle;
    check({son, son_oe}, 2'b11);
    wr_reg(`SWP_CTRL_OFF, 32'h0);
    settle;
    check({son, son_oe}, 2'b01);
    strap(5'b00000);
    $display("supply test done");
  endtask

  task t_button;
    @(posedge aclk);
    {st_load, st_val} <= {1'b1, 3'h3};
    @(posedge aclk);
    st_load <= 1'b0;
    settle;
    rd_reg(`SWP_STATUS_OFF);
    check(rdv[7:6], 2'b01);
    @(posedge aclk);
    {st_load, st_val} <= {1'b1, 3'h5};
    @(posedge aclk);
    st_load <= 1'b0;
    settle;
    rd_reg(`SWP_STATUS_OFF);
    check(rdv[7:6], 2'b11);
    button_n <= 1'b0;
    repeat (DEB - 2) @(posedge aclk);
    button_n <= 1'b1;
    repeat (12) @(posedge aclk);
    @(negedge aclk);
    check({pbo_oe, pur_oe}, 2'b00);
    @(posedge aclk);
    button_n <= 1'b0;
    repeat (DEB + 8) @(posedge aclk);
    @(negedge aclk);
    check({pbo_n, pbo_oe}, 2'b01);
    check({pur_n, pur_oe, slp3}, 3'b010);
    rd_reg(`SWP_EVENT_OFF);
    check(rdv, 32'h1);
    button_n <= 1'b1;
    repeat (DEB + 8) @(posedge aclk);
    wr_reg(`SWP_EVENT_OFF, 32'h1);
    settle;
    check({pbo_oe, pur_oe}, 2'b00);
    wr_reg(`SWP_CTRL_OFF, 32'h2);
    settle;
    check({pbo_n, pbo_oe}, 2'b01);
    wr_reg(`SWP_CTRL_OFF, 32'h0);
    $display("button test done");
  endtask

  task t_ring;
    pulse;
    pulse;
    repeat (60) @(posedge aclk);
    pulse;
    rd_reg(`SWP_EVENT_OFF);
    check(rdv, 32'h0);
    pulse;
    pulse;
    rd_reg(`SWP_EVENT_OFF);
    check(rdv, 32'h2);
    check(pur_oe, 1'b1);
    wr_reg(`SWP_EVENT_OFF, 32'h2);
    rd_reg(`SWP_EVENT_OFF);
    check(rdv, 32'h0);
    $display("ring test done");
  endtask

  task t_led;
    integer m, n, t1, t2, e;
    logic   p1, p2;
    for (m = 0; m < 6; m = m + 1) begin
      wr_reg(`SWP_CTRL_OFF, (m << 4) | (m << 8));
      settle;
      {p1, p2, t1, t2} = {led1, led2, 64'h0};
      for (n = 0; n < 256; n = n + 1) begin
        @(negedge aclk);
        t1 = t1 + (led1 !== p1);
        t2 = t2 + (led2 !== p2);
        {p1, p2} = {led1, led2};
      end
      e = (m == 5) ? 64 : (m == 4) ? 16 : (m == 3) ? 8 : (m == 2) ? 4 : 0;
      check({t1 >= e - 1 && t1 <= e + 1, t2 >= e - 1 && t2 <= e + 1}, 2'b11);
      if (m < 2) check({led1, led2}, {2{m[0]}});
    end
    $display("led test done");
  endtask

  task t_gpio;
    strap(5'b10011);
    check(tmode, 1'b1);
    rd_reg(`SWP_CFGBASE_OFF);
    check(rdv, 32'h0000_004e);
    io(16'h004e);
    check({ihit, dhit}, 2'b10);
    io(16'h002e);
    check({ihit, dhit}, 2'b00);
    wr_reg(`SWP_CTRL_OFF, 32'h4);
    settle;
    check({pbo_n, pbo_oe, son, son_oe}, 4'b1101);
    wr_reg(`SWP_CTRL_OFF, 32'h8);
    settle;
    check({pbo_n, pbo_oe, son, son_oe}, 4'b0111);
    @(posedge aclk);
    {test_s, base_s, plc0_s} <= 3'b000;
    repeat (20) @(posedge aclk);
    rd_reg(`SWP_CFGBASE_OFF);
    check({tmode, rdv}, {1'b1, 32'h0000_004e});
    strap(5'b00000);
    rd_reg(`SWP_CFGBASE_OFF);
    check({tmode, rdv}, {1'b0, 32'h0000_002e});
    $display("gpio test done");
  endtask

  initial begin
    {num_errors, total_checks, cyc} = 96'h0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, st_load, st_val} = 10'h0;
    {base_s, plc0_s, plc1_s, pol_s, test_s, awaddr, wdata, araddr, io_addr} = 117'h0;
    {sys_reset_n, button_n, ring_n} = 3'b111;
    wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    t_reset;
    t_supply;
    t_button;
    t_ring;
    t_led;
    t_gpio;
    test_done;
  end
endmodule // test_strap_and_wakeup_pins
`default_nettype wire
